//--- design/pvmr_regs.sv
`timescale 1ns/1ps
`include "pvmr_defs.svh"
module pvmr_regs
   import pvmr_pkg::*;
#(
   parameter int NUM_ADV = 13
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic soft_reset,
   input wire logic [3:0] config_straps,
   input wire logic mgmt_wr,
   input wire logic mgmt_rd,
   input wire logic [4:0] mgmt_index,
   input wire logic [15:0] mgmt_wdata,
   output logic [15:0] mgmt_rdata,
   input wire logic [4:0] frame_phy_addr,
   output logic frame_addr_match,
   input wire logic [NUM_ADV*16-1:0] adv_reg_values,
   input wire logic mac_clk_25_sel,
   input wire logic link_10base_t,
   input wire logic link_half_duplex,
   input wire logic auto_mdix_disable,
   input wire logic auto_pair01_crossed,
   input wire logic auto_pair23_crossed,
   input wire logic pd_detect_10,
   input wire logic pd_detect_100,
   input wire logic adv_10_half,
   input wire logic adv_100_half,
   output logic early_rxdv_en,
   output logic mii_loopback_active,
   output logic crc_count_tx,
   output logic [4:0] station_address_field,
   output logic [4:0] scrambler_seed,
   output logic [4:0] operating_mode_field,
   output logic [2:0] tx_fifo_depth_bytes,
   output logic [1:0] indicator_mode_select,
   output logic pair01_crossed,
   output logic pair23_crossed,
   output logic pd_accept
);
   // the address field is seven bits wide, so at most 128 slots
   if (NUM_ADV < 1 || NUM_ADV > 128) begin : g_num_adv_check
      $error("NUM_ADV must lie in 1..128");
   end

   logic rst_s1_q;
   logic rst_s2_q;
   logic strap_load_q;
   logic early_rxdv_q;
   logic hd_lb_dis_q;
   logic crc_src_q;
   logic [4:0] station_addr_q;
   logic [4:0] mode_q;
   logic [1:0] fifo_q;
   logic [1:0] led_q;
   logic rsvd3_q;
   logic mdi01_q;
   logic mdi23_q;
   logic cpd_q;
   logic [7:0] aa_rsvd_q;
   logic [6:0] aa_addr_q;
   pvmr_word_t adv_data_q;
   pvmr_word_t rdata_q;
   logic match_q;

   // reset release through two stages
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // strap capture pulse on the first cycle after release
   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         strap_load_q <= 1'b1;
      end else begin
         strap_load_q <= 1'b0;
      end
   end

   function automatic logic wr_hit(input logic wr, input pvmr_index_t idx, input pvmr_index_t reg_idx);
      wr_hit = wr && (idx == reg_idx);
   endfunction

   // one slot per advanced register
   pvmr_word_t adv_slot [NUM_ADV];
   for (genvar g = 0; g < NUM_ADV; g++) begin : g_adv_slot
      assign adv_slot[g] = adv_reg_values[g*16 +: 16];
   end

   // addresses beyond the last slot latch zero
   function automatic pvmr_word_t adv_pick(input logic [6:0] sel);
      adv_pick = `PVMR_RST_ADV_DATA;
      for (int i = 0; i < NUM_ADV; i++) begin
         if (sel == 7'(i)) begin
            adv_pick = adv_slot[i];
         end
      end
   endfunction

   logic wr_sm;
   logic wr_em;
   logic wr_aa;
   assign wr_sm = wr_hit(mgmt_wr, mgmt_index, `PVMR_IDX_SPECIAL_MODES);
   assign wr_em = wr_hit(mgmt_wr, mgmt_index, `PVMR_IDX_EXT_MODE);
   assign wr_aa = wr_hit(mgmt_wr, mgmt_index, `PVMR_IDX_ADV_ADDR);

   // loopback disable, kept over soft reset
   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         hd_lb_dis_q <= 1'b0;
      end else if (wr_sm) begin
         hd_lb_dis_q <= mgmt_wdata[`PVMR_SM_HD_LB_DIS];
      end
   end

   // station address, kept over soft reset, strap default
   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         station_addr_q <= 5'h00;
      end else if (strap_load_q) begin
         station_addr_q <= {3'h0, config_straps[1:0]};
      end else if (wr_sm) begin
         station_addr_q <= mgmt_wdata[`PVMR_SM_ADDR_MSB:0];
      end
   end

   // operating mode, kept over soft reset, strap default
   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         mode_q <= 5'h00;
      end else if (strap_load_q) begin
         mode_q <= {3'h0, config_straps[3:2]};
      end else if (wr_em) begin
         mode_q <= mgmt_wdata[`PVMR_EM_MODE_LSB +: 5];
      end
   end

   // special modes fields that soft reset returns to defaults
   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         early_rxdv_q <= 1'b0;
         crc_src_q <= 1'b0;
      end else if (soft_reset) begin
         early_rxdv_q <= 1'b0;
         crc_src_q <= 1'b0;
      end else if (wr_sm) begin
         early_rxdv_q <= mgmt_wdata[`PVMR_SM_EARLY_RXDV];
         crc_src_q <= mgmt_wdata[`PVMR_SM_CRC_SRC];
      end
   end

   // extended mode fields that soft reset returns to defaults
   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         fifo_q <= `PVMR_RST_FIFO;
         led_q <= `PVMR_RST_LED;
         rsvd3_q <= `PVMR_RST_RSVD3;
         mdi01_q <= 1'b0;
         mdi23_q <= 1'b0;
         cpd_q <= 1'b0;
      end else if (soft_reset) begin
         fifo_q <= `PVMR_RST_FIFO;
         led_q <= `PVMR_RST_LED;
         rsvd3_q <= `PVMR_RST_RSVD3;
         mdi01_q <= 1'b0;
         mdi23_q <= 1'b0;
         cpd_q <= 1'b0;
      end else begin
         if (wr_em) begin
            fifo_q <= mgmt_wdata[`PVMR_EM_FIFO_LSB +: 2];
            led_q <= mgmt_wdata[`PVMR_EM_LED_LSB +: 2];
            rsvd3_q <= mgmt_wdata[`PVMR_EM_RSVD3];
            mdi01_q <= mgmt_wdata[`PVMR_EM_MDI01];
            mdi23_q <= mgmt_wdata[`PVMR_EM_MDI23];
            cpd_q <= mgmt_wdata[`PVMR_EM_CPD];
         end
      end
   end

   // advanced address port and latched read data
   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         aa_rsvd_q <= `PVMR_RST_AA_RSVD;
         aa_addr_q <= `PVMR_RST_AA_ADDR;
         adv_data_q <= `PVMR_RST_ADV_DATA;
      end else if (soft_reset) begin
         aa_rsvd_q <= `PVMR_RST_AA_RSVD;
         aa_addr_q <= `PVMR_RST_AA_ADDR;
         adv_data_q <= `PVMR_RST_ADV_DATA;
      end else if (wr_aa) begin
         aa_rsvd_q <= mgmt_wdata[`PVMR_AA_RSVD_LSB +: 8];
         aa_addr_q <= mgmt_wdata[`PVMR_AA_ADDR_MSB:0];
         if (mgmt_wdata[`PVMR_AA_READ]) begin
            adv_data_q <= adv_pick(mgmt_wdata[`PVMR_AA_ADDR_MSB:0]);
         end
      end
   end

   pvmr_word_t sm_word;
   pvmr_word_t em_word;
   pvmr_word_t aa_word;

   // special modes read image, reserved bits low
   always_comb begin
      sm_word = 16'h0000;
      sm_word[`PVMR_SM_EARLY_RXDV] = early_rxdv_q;
      sm_word[`PVMR_SM_HD_LB_DIS] = hd_lb_dis_q;
      sm_word[`PVMR_SM_CRC_SRC] = crc_src_q;
      sm_word[`PVMR_SM_MCLK_LOW] = mac_clk_25_sel;
      sm_word[`PVMR_SM_ADDR_MSB:0] = station_addr_q;
   end

   // extended mode read image, bits 8:6 low
   always_comb begin
      em_word = 16'h0000;
      em_word[`PVMR_EM_MODE_LSB +: 5] = mode_q;
      em_word[`PVMR_EM_FIFO_LSB +: 2] = fifo_q;
      em_word[`PVMR_EM_LED_LSB +: 2] = led_q;
      em_word[`PVMR_EM_RSVD3] = rsvd3_q;
      em_word[`PVMR_EM_MDI01] = mdi01_q;
      em_word[`PVMR_EM_MDI23] = mdi23_q;
      em_word[`PVMR_EM_CPD] = cpd_q;
   end

   // address port read image, read bit never stored
   always_comb begin
      aa_word = 16'h0000;
      aa_word[`PVMR_AA_RSVD_LSB +: 8] = aa_rsvd_q;
      aa_word[`PVMR_AA_ADDR_MSB:0] = aa_addr_q;
   end

   // read data, one cycle after the read strobe
   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         rdata_q <= 16'h0000;
      end else if (mgmt_rd) begin
         case (mgmt_index)
            `PVMR_IDX_SPECIAL_MODES: begin
               rdata_q <= sm_word;
            end
            `PVMR_IDX_EXT_MODE: begin
               rdata_q <= em_word;
            end
            `PVMR_IDX_ADV_ADDR: begin
               rdata_q <= aa_word;
            end
            `PVMR_IDX_ADV_DATA: begin
               rdata_q <= adv_data_q;
            end
            default: begin
               rdata_q <= 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         match_q <= 1'b0;
      end else begin
         match_q <= (frame_phy_addr == station_addr_q);
      end
   end

   assign mgmt_rdata = rdata_q;
   assign frame_addr_match = match_q;
   assign early_rxdv_en = early_rxdv_q;
   assign mii_loopback_active = !hd_lb_dis_q && link_10base_t && link_half_duplex;
   assign crc_count_tx = crc_src_q;
   assign station_address_field = station_addr_q;
   assign scrambler_seed = station_addr_q;
   assign operating_mode_field = mode_q;
   assign tx_fifo_depth_bytes = `PVMR_FIFO_BASE_BYTES + {1'b0, fifo_q};
   assign indicator_mode_select = led_q;
   assign pair01_crossed = auto_mdix_disable ? mdi01_q : auto_pair01_crossed;
   assign pair23_crossed = auto_mdix_disable ? mdi23_q : auto_pair23_crossed;
   assign pd_accept = cpd_q ? ((pd_detect_10 && adv_10_half) || (pd_detect_100 && adv_100_half))
                            : (pd_detect_10 || pd_detect_100);
endmodule // pvmr_regs

//--- design/pvmr_defs.svh
`ifndef PVMR_DEFS_SVH
`define PVMR_DEFS_SVH
// management indices
`define PVMR_IDX_SPECIAL_MODES 5'h12
`define PVMR_IDX_EXT_MODE 5'h13
`define PVMR_IDX_ADV_ADDR 5'h14
`define PVMR_IDX_ADV_DATA 5'h15
// special modes fields
`define PVMR_SM_EARLY_RXDV 15
`define PVMR_SM_HD_LB_DIS 14
`define PVMR_SM_CRC_SRC 7
`define PVMR_SM_MCLK_LOW 6
`define PVMR_SM_ADDR_MSB 4
// extended mode fields
`define PVMR_EM_MODE_LSB 11
`define PVMR_EM_FIFO_LSB 9
`define PVMR_EM_LED_LSB 4
`define PVMR_EM_RSVD3 3
`define PVMR_EM_MDI01 2
`define PVMR_EM_MDI23 1
`define PVMR_EM_CPD 0
// advanced address port fields
`define PVMR_AA_READ 15
`define PVMR_AA_RSVD_LSB 7
`define PVMR_AA_ADDR_MSB 6
// reset values, and the base byte count added to the fifo field
`define PVMR_RST_FIFO 2'h0
`define PVMR_RST_LED 2'h3
`define PVMR_RST_RSVD3 1'h1
`define PVMR_RST_AA_RSVD 8'h00
`define PVMR_RST_AA_ADDR 7'h00
`define PVMR_RST_ADV_DATA 16'h0000
`define PVMR_FIFO_BASE_BYTES 3'h4
`endif

//--- design/pvmr_pkg.sv
package pvmr_pkg;
   typedef logic [15:0] pvmr_word_t;
   typedef logic [4:0] pvmr_index_t;
   typedef enum logic [1:0] {
      PVMR_LED_RSVD,
      PVMR_LED_MODE1,
      PVMR_LED_MODE2,
      PVMR_LED_MODE3
   } pvmr_led_t;
endpackage

//--- tb/pvmr_regs_monitor.sv
`timescale 1ns/1ps
module pvmr_regs_monitor (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic soft_reset,
   input wire logic mgmt_wr,
   input wire logic mgmt_rd,
   input wire logic [4:0] mgmt_index,
   input wire logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata,
   input wire logic [4:0] frame_phy_addr,
   input wire logic frame_addr_match,
   input wire logic early_rxdv_en,
   input wire logic crc_count_tx,
   input wire logic [4:0] station_address_field,
   input wire logic [4:0] scrambler_seed,
   input wire logic [1:0] indicator_mode_select
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   sequence s_wr18;
      mgmt_wr && mgmt_index == 5'h12 && !soft_reset;
   endsequence
   sequence s_wr19;
      mgmt_wr && mgmt_index == 5'h13 && !soft_reset;
   endsequence
   a_wr_special: assert property (s_wr18 |=> early_rxdv_en == $past(mgmt_wdata[15]))
      else $error("early valid enable not written");
   a_crc_source: assert property (s_wr18 |=> crc_count_tx == $past(mgmt_wdata[7]))
      else $error("crc source not written");
   a_addr_write: assert property (s_wr18 |=> station_address_field == $past(mgmt_wdata[4:0]))
      else $error("station address not written");
   a_led_write: assert property (s_wr19 |=> indicator_mode_select == $past(mgmt_wdata[5:4]))
      else $error("indicator mode not written");
   a_soft_clear: assert property (soft_reset |=> !early_rxdv_en && indicator_mode_select == 2'h3)
      else $error("soft reset values wrong");
   a_soft_keep: assert property (soft_reset && !mgmt_wr && $past(resetn, 3) |=> $stable(station_address_field))
      else $error("address lost on soft reset");
   a_addr_match: assert property ($past(resetn, 3) |->
      frame_addr_match == ($past(frame_phy_addr) == $past(station_address_field)))
      else $error("address match wrong");
   a_seed_copy: assert property (scrambler_seed == station_address_field)
      else $error("scrambler seed differs");
   a_rdata_hold: assert property (!mgmt_rd && !soft_reset |=> $stable(mgmt_rdata))
      else $error("read data moved without read");
endmodule // pvmr_regs_monitor
bind pvmr_regs pvmr_regs_monitor u_mon (.mclk, .resetn, .soft_reset, .mgmt_wr, .mgmt_rd, .mgmt_index,
   .mgmt_wdata, .mgmt_rdata, .frame_phy_addr, .frame_addr_match, .early_rxdv_en, .crc_count_tx,
   .station_address_field, .scrambler_seed, .indicator_mode_select);

//--- tb/pvmr_host_model.sv
`timescale 1ns/1ps
module pvmr_host_model (
   input wire logic mclk,
   input wire logic [15:0] mgmt_rdata,
   output logic mgmt_wr,
   output logic mgmt_rd,
   output logic [4:0] mgmt_index,
   output logic [15:0] mgmt_wdata
);
   initial begin
      {mgmt_wr, mgmt_rd, mgmt_index, mgmt_wdata} = 23'h000000;
   end
   // released strobes drop low, index and data lines show inverse, not the last value
   task xfer(input logic w, input logic [4:0] i, input logic [15:0] d, output logic [15:0] q);
      @(posedge mclk) #1;
      {mgmt_wr, mgmt_rd, mgmt_index, mgmt_wdata} = {w, !w, i, d};
      @(posedge mclk) #1;
      {mgmt_wr, mgmt_rd, mgmt_index, mgmt_wdata} = {2'b00, ~i, ~d};
      q = mgmt_rdata;
   endtask
   task wr_ext(input logic [4:0] md, input logic [1:0] ff, ld, input logic [2:0] lo, output logic [15:0] q);
      xfer(1'b1, 5'h13, {md, ff, 3'b000, ld, 1'b1, lo}, q);
   endtask
   task adv_rd(input logic [6:0] a, output logic [15:0] q);
      xfer(1'b1, 5'h14, {1'b1, 8'h03, a}, q);
      xfer(1'b0, 5'h15, 16'h0000, q);
   endtask
endmodule // pvmr_host_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
   import pvmr_pkg::*;
   logic mclk, resetn, soft_reset, mgmt_wr, mgmt_rd, frame_addr_match, mac_clk_25_sel, link_10base_t;
   logic link_half_duplex, auto_mdix_disable, auto_pair01_crossed, auto_pair23_crossed, pd_detect_10;
   logic pd_detect_100, adv_10_half, adv_100_half, early_rxdv_en, mii_loopback_active, crc_count_tx;
   logic pair01_crossed, pair23_crossed, pd_accept;
   logic [3:0] config_straps;
   logic [4:0] mgmt_index, frame_phy_addr, station_address_field, scrambler_seed, operating_mode_field, md;
   logic [2:0] tx_fifo_depth_bytes;
   logic [1:0] indicator_mode_select;
   pvmr_word_t mgmt_wdata, mgmt_rdata, q, w;
   logic [13*16-1:0] adv_reg_values;
   logic [31:0] lf = 32'h00014859;
   int error_cnt = 0, checked = 0, cyc = 0;
   logic [6:0] al [4] = '{7'h00, 7'h0C, 7'h0D, 7'h7F};
   pvmr_regs u_dut (.mclk, .resetn, .soft_reset, .config_straps, .mgmt_wr, .mgmt_rd, .mgmt_index, .mgmt_wdata,
      .mgmt_rdata, .frame_phy_addr, .frame_addr_match, .adv_reg_values, .mac_clk_25_sel, .link_10base_t,
      .link_half_duplex, .auto_mdix_disable, .auto_pair01_crossed, .auto_pair23_crossed, .pd_detect_10,
      .pd_detect_100, .adv_10_half, .adv_100_half, .early_rxdv_en, .mii_loopback_active, .crc_count_tx,
      .station_address_field, .scrambler_seed, .operating_mode_field, .tx_fifo_depth_bytes,
      .indicator_mode_select, .pair01_crossed, .pair23_crossed, .pd_accept);
   pvmr_host_model u_host (.mclk, .mgmt_rdata, .mgmt_wr, .mgmt_rd, .mgmt_index, .mgmt_wdata);
   function automatic logic [15:0] nxt();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[15:0];
   endfunction
   function automatic logic pd_exp(input logic c);
      return c ? (pd_detect_10 & adv_10_half) | (pd_detect_100 & adv_100_half) : pd_detect_10 | pd_detect_100;
   endfunction
   task rand_in;
      {mac_clk_25_sel, link_10base_t, link_half_duplex, auto_mdix_disable, auto_pair01_crossed,
         auto_pair23_crossed, pd_detect_10, pd_detect_100, adv_10_half, adv_100_half} = 10'(nxt());
   endtask
   task automatic chk(input string n, input logic [15:0] e, s);
      checked++;
      if (s !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, s);
         error_cnt++;
      end
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         complete_run();
      end
      #1 frame_phy_addr = cyc[0] ? station_address_field : lf[4:0];
   end
   initial begin
      {resetn, soft_reset, frame_phy_addr} = 7'h00;
      config_straps = 4'(nxt());
      for (int i = 0; i < 13; i++) adv_reg_values[i*16+:16] = nxt();
      rand_in();
      repeat (16) @(posedge mclk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge mclk);
      md = {3'h0, config_straps[3:2]};
      chk("addr", 16'(config_straps[1:0]), 16'(station_address_field));
      chk("mode", 16'(md), 16'(operating_mode_field));
      u_host.xfer(1'b0, 5'h13, 16'h0000, q);
      chk("r19", {md, 11'h038}, q);
      u_host.xfer(1'b0, 5'h14, 16'h0000, q);
      chk("r20", 16'h0000, q);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         w = (i == 0) ? 16'hFFFF : nxt();
         rand_in();
         u_host.xfer(1'b1, 5'h12, w, q);
         u_host.xfer(1'b0, 5'h12, 16'h0000, q);
         chk("r18", {w[15:14], 6'h00, w[7], mac_clk_25_sel, 1'b0, w[4:0]}, q);
         chk("loop", 16'(!w[14] & link_10base_t & link_half_duplex), 16'(mii_loopback_active));
         chk("early", 16'(w[15]), 16'(early_rxdv_en));
      end
      $display("test special done");
      for (int i = 0; i < 4; i++) begin
         w = nxt();
         rand_in();
         auto_mdix_disable = i[0];
         u_host.wr_ext(md, i[1:0], i[1:0], w[2:0], q);
         u_host.xfer(1'b0, 5'h13, 16'h0000, q);
         chk("r19", {md, i[1:0], 3'b000, i[1:0], 1'b1, w[2:0]}, q);
         chk("fifo", 16'(3'h4 + i[1:0]), 16'(tx_fifo_depth_bytes));
         chk("p01", 16'(i[0] ? w[2] : auto_pair01_crossed), 16'(pair01_crossed));
         chk("p23", 16'(i[0] ? w[1] : auto_pair23_crossed), 16'(pair23_crossed));
         chk("pd", 16'(pd_exp(w[0])), 16'(pd_accept));
      end
      $display("test extended done");
      foreach (al[k]) begin
         u_host.adv_rd(al[k], q);
         chk("adv", (al[k] < 7'h0D) ? adv_reg_values[al[k]*16+:16] : 16'h0000, q);
         u_host.xfer(1'b0, 5'h14, 16'h0000, q);
         chk("r20", {1'b0, 8'h03, al[k]}, q);
      end
      $display("test advanced done");
      u_host.xfer(1'b1, 5'h12, 16'hC09F, q);
      @(posedge mclk) #1 soft_reset = 1'b1;
      @(posedge mclk) #1 soft_reset = 1'b0;
      u_host.xfer(1'b0, 5'h12, 16'h0000, q);
      chk("soft", {9'h080, mac_clk_25_sel, 1'b0, 5'h1F}, q);
      chk("smode", 16'(md), 16'(operating_mode_field));
      u_host.xfer(1'b0, 5'h00, 16'h0000, q);
      chk("unmapped", 16'h0000, q);
      $display("test soft reset done");
      complete_run();
   end
endmodule // tb
